/* csr_pkg.sv */
/*
 * Package for the channel status and sample register group: offsets, field
 * positions, reset values and the read-request carrier.
 * Assumes a register access port driven by the device's interface decoders.
 */
// Notes on behaviour
// - offset limit reached sets offset fault flag
// - status read or report clears offset flag
// - psi5 option keeps offset flag after report
// - failed psi5 startup self-test sets fail flag
// - self-test fail flag clears only by reset
// - status mirror always equals primary status
// - mirror read has primary read side effects
// - mirror bit order fault..init in progress
// - sample0 word at 0x62/0x63, selected, resets zero
// - sample1 word at 0x64/0x65, selected, resets zero
// - i2c low read freezes high until read
// - readable in dsi3, spi, i2c, psi5 programming
// - factory config readable only before init lock
// - range code 0010 medium, 0100 high
// - axis code 00 x, 01 y, 10 z
package csr_pkg;
	// ********************
	// register offsets
	// ********************
	localparam logic [7:0] ADDR_CH_STAT = 8'h60;
	localparam logic [7:0] ADDR_STAT_MIRROR = 8'h61;
	localparam logic [7:0] ADDR_S0_LOW = 8'h62;
	localparam logic [7:0] ADDR_S0_HIGH = 8'h63;
	localparam logic [7:0] ADDR_S1_LOW = 8'h64;
	localparam logic [7:0] ADDR_S1_HIGH = 8'h65;
	localparam logic [7:0] ADDR_FACT_CFG = 8'ha0;
	// ********************
	// fields and reset values
	// ********************
	localparam int CH_STAT_OFFS_BIT = 1;
	localparam int CH_STAT_STFAIL_BIT = 0;
	localparam logic [7:0] STAT_MIRROR_MASK = 8'hbf;
	localparam logic [7:0] FACT_CFG_MASK = 8'hf3;
	localparam logic [3:0] RANGE_MEDIUM = 4'h2;
	localparam logic [3:0] RANGE_HIGH = 4'h4;
	localparam logic [1:0] AXIS_X = 2'h0;
	localparam logic [1:0] AXIS_Y = 2'h1;
	localparam logic [1:0] AXIS_Z = 2'h2;
	localparam logic [15:0] SAMPLE_RESET = 16'h0000;
	localparam logic [7:0] RDATA_RESET = 8'h00;

	typedef enum logic [1:0] {CSR_MODE_DSI3, CSR_MODE_SPI, CSR_MODE_I2C, CSR_MODE_PSI5} csr_mode_e;

	typedef struct packed {
		logic valid;
		logic [7:0] addr;
	} csr_rd_s;

	typedef struct packed {
		logic channel_fault;
		logic link_fault;
		logic memory_or_thermal_fault;
		logic supply_fault;
		logic factory_test_active;
		logic reset_occurred;
		logic init_in_progress;
	} csr_device_status_primary_s;
endpackage : csr_pkg

/* csr_regs.sv */
/*
 * Channel status, status mirror, sample words and factory config byte.
 * Assumes all inputs come from logic on i_clk; reads arrive as one-cycle
 * requests and the answer appears one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none
module csr_regs
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire csr_pkg::csr_rd_s i_rd,
	input wire csr_pkg::csr_mode_e i_mode,
	input wire logic i_psi5_prog,
	input wire logic i_offset_limit,
	input wire logic i_tx_offs_report,
	input wire logic i_psi5_keep_offs,
	input wire logic i_selftest_fail,
	input wire csr_pkg::csr_device_status_primary_s i_device_status_primary,
	input wire logic [15:0] i_sample0,
	input wire logic [15:0] i_sample1,
	input wire logic [1:0] i_sample0_source_select,
	input wire logic [1:0] i_sample1_source_select,
	input wire logic i_init_done_lock,
	input wire logic [3:0] i_factory_scale_code,
	input wire logic [1:0] i_factory_axis,
	output logic [7:0] o_rdata,
	output logic o_rvalid,
	output logic o_device_status_primary_read,
	output logic o_offset_fault,
	output logic o_startup_selftest_fail_flag,
	output logic [1:0] o_sample0_source,
	output logic [1:0] o_sample1_source
);
	import csr_pkg::*;

	logic offs_ff;
	logic stfail_ff;
	logic [7:0] hold0_ff;
	logic [7:0] hold1_ff;
	logic frz0_ff;
	logic frz1_ff;
	logic [7:0] nxt_rdata;
	logic rd_ok;
	logic i2c;
	logic [7:0] mirror;
	logic [7:0] fact;

	// mode gate: psi5 only while in programming mode
	assign rd_ok = i_rd.valid && (i_mode != CSR_MODE_PSI5 || i_psi5_prog);
	assign i2c = (i_mode == CSR_MODE_I2C);
	assign mirror = {i_device_status_primary.channel_fault, 1'b0, i_device_status_primary.link_fault,
		i_device_status_primary.memory_or_thermal_fault, i_device_status_primary.supply_fault,
		i_device_status_primary.factory_test_active, i_device_status_primary.reset_occurred,
		i_device_status_primary.init_in_progress};
	assign fact = {i_factory_scale_code, 2'b00, i_factory_axis};

	// ********************
	// channel error flags
	// ********************
	// set wins over a clear in the same cycle so no fault is lost
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			offs_ff <= 1'b0;
		else if (i_offset_limit)
			offs_ff <= 1'b1;
		else if (!(i_mode == CSR_MODE_PSI5 && i_psi5_keep_offs) &&
			((rd_ok && i_rd.addr == ADDR_CH_STAT) || i_tx_offs_report))
			offs_ff <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			stfail_ff <= 1'b0;
		else if (i_selftest_fail)
			stfail_ff <= 1'b1;
	end

	// ********************
	// i2c high byte freeze
	// ********************
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			hold0_ff <= RDATA_RESET;
			frz0_ff <= 1'b0;
		end
		else if (rd_ok && i2c && i_rd.addr == ADDR_S0_LOW)
		begin
			hold0_ff <= i_sample0[15:8];
			frz0_ff <= 1'b1;
		end
		else if (rd_ok && i_rd.addr == ADDR_S0_HIGH)
			frz0_ff <= 1'b0;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			hold1_ff <= RDATA_RESET;
			frz1_ff <= 1'b0;
		end
		else if (rd_ok && i2c && i_rd.addr == ADDR_S1_LOW)
		begin
			hold1_ff <= i_sample1[15:8];
			frz1_ff <= 1'b1;
		end
		else if (rd_ok && i_rd.addr == ADDR_S1_HIGH)
			frz1_ff <= 1'b0;
	end

	// ********************
	// read mux
	// ********************
	// no write port: read-only registers ignore writes by construction
	always_comb
	begin
		nxt_rdata = RDATA_RESET;
		unique case (i_rd.addr)
			ADDR_CH_STAT:
				nxt_rdata = {6'h00, offs_ff, stfail_ff};
			ADDR_STAT_MIRROR:
				nxt_rdata = mirror;
			ADDR_S0_LOW:
				nxt_rdata = i_sample0[7:0];
			ADDR_S0_HIGH:
				nxt_rdata = frz0_ff ? hold0_ff : i_sample0[15:8];
			ADDR_S1_LOW:
				nxt_rdata = i_sample1[7:0];
			ADDR_S1_HIGH:
				nxt_rdata = frz1_ff ? hold1_ff : i_sample1[15:8];
			ADDR_FACT_CFG:
				nxt_rdata = i_init_done_lock ? RDATA_RESET : fact;
			default:
				nxt_rdata = RDATA_RESET;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_rdata <= RDATA_RESET;
			o_rvalid <= 1'b0;
			o_device_status_primary_read <= 1'b0;
		end
		else
		begin
			o_rdata <= rd_ok ? nxt_rdata : RDATA_RESET;
			o_rvalid <= rd_ok;
			// mirror read reaches the primary status clear-on-read logic
			o_device_status_primary_read <= rd_ok && i_rd.addr == ADDR_STAT_MIRROR;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_offset_fault <= 1'b0;
			o_startup_selftest_fail_flag <= 1'b0;
			o_sample0_source <= 2'h0;
			o_sample1_source <= 2'h0;
		end
		else
		begin
			o_offset_fault <= offs_ff;
			o_startup_selftest_fail_flag <= stfail_ff;
			o_sample0_source <= i_sample0_source_select;
			o_sample1_source <= i_sample1_source_select;
		end
	end

	// ********************
	// checks
	// ********************
	a_offs_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_offset_limit |=> offs_ff) else $error("offset flag not set");
	a_offs_clear: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_tx_offs_report && !i_offset_limit && i_mode != CSR_MODE_PSI5) |=> !offs_ff)
		else $error("offset flag not cleared");
	a_offs_keep: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(offs_ff && i_mode == CSR_MODE_PSI5 && i_psi5_keep_offs) |=> offs_ff)
		else $error("offset flag lost in keep mode");
	a_stfail_set: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		i_selftest_fail |=> stfail_ff ##1 o_startup_selftest_fail_flag)
		else $error("self-test fail not flagged");
	a_stfail_sticky: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		stfail_ff |=> stfail_ff) else $error("self-test fail cleared");
	a_mirror_data: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_STAT_MIRROR) |=> (o_rdata == $past(mirror) && o_device_status_primary_read))
		else $error("mirror read wrong");
	a_mirror_rsvd: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(o_rvalid && o_device_status_primary_read) |-> !o_rdata[6]) else $error("mirror reserved set");
	// the host leaves one idle cycle between its reads; this check assumes two, so the pair spans four edges
	a_freeze_high: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i2c && i_rd.addr == ADDR_S0_LOW) ##1 (!i_rd.valid) [*2]
		##1 (rd_ok && i_rd.addr == ADDR_S0_HIGH)
		|=> o_rdata == $past(i_sample0[15:8], 4)) else $error("high byte not frozen");

	a_freeze_high1: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i2c && i_rd.addr == ADDR_S1_LOW) ##1 (!i_rd.valid) [*2]
		##1 (rd_ok && i_rd.addr == ADDR_S1_HIGH)
		|=> o_rdata == $past(i_sample1[15:8], 4)) else $error("high byte one not frozen");
	a_fact_lock: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_FACT_CFG && i_init_done_lock) |=> o_rdata == 8'h00)
		else $error("factory byte visible after lock");
	a_mode_gate: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(i_rd.valid && i_mode == CSR_MODE_PSI5 && !i_psi5_prog) |=> !o_rvalid)
		else $error("read answered outside programming mode");

	// ********************
	// answer timing
	// ********************
	a_rvalid_answer: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		rd_ok |=> o_rvalid) else $error("accepted read not answered");

	a_rvalid_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!rd_ok |=> !o_rvalid) else $error("answer without a read");

	a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		!rd_ok |=> o_rdata == RDATA_RESET) else $error("read data not zero when idle");

	a_dsr_with_answer: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		o_device_status_primary_read |-> o_rvalid) else $error("status read strobe without answer");

	// ********************
	// flag behaviour
	// ********************
	a_offs_read_clr: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_CH_STAT && !i_offset_limit && i_mode != CSR_MODE_PSI5)
		|=> !offs_ff) else $error("offset flag not cleared by read");

	a_offs_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!offs_ff && !i_offset_limit) |=> !offs_ff) else $error("offset flag set alone");

	a_stfail_quiet: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(!stfail_ff && !i_selftest_fail) |=> !stfail_ff) else $error("self-test flag set alone");

	a_offs_out: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		offs_ff |=> o_offset_fault) else $error("offset output lags flag");

	a_stfail_out: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		stfail_ff |=> o_startup_selftest_fail_flag) else $error("self-test output lags flag");

	a_stat_read: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_CH_STAT && offs_ff) |=> o_rdata[CH_STAT_OFFS_BIT])
		else $error("status read lost offset flag");

	// ********************
	// sample words
	// ********************
	a_low0_live: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_S0_LOW) |=> o_rdata == $past(i_sample0[7:0]))
		else $error("sample0 low byte wrong");

	a_low1_live: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_S1_LOW) |=> o_rdata == $past(i_sample1[7:0]))
		else $error("sample1 low byte wrong");

	a_high0_live: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_S0_HIGH && !frz0_ff)
		|=> o_rdata == $past(i_sample0[15:8])) else $error("sample0 high byte wrong");

	a_high1_live: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_S1_HIGH && !frz1_ff)
		|=> o_rdata == $past(i_sample1[15:8])) else $error("sample1 high byte wrong");

	a_src0_copy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		1'b1 |=> o_sample0_source == $past(i_sample0_source_select))
		else $error("sample0 source not copied");

	a_src1_copy: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		1'b1 |=> o_sample1_source == $past(i_sample1_source_select))
		else $error("sample1 source not copied");

	// ********************
	// factory byte
	// ********************
	a_fact_open: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_FACT_CFG && !i_init_done_lock)
		|=> o_rdata[7:4] == $past(i_factory_scale_code)) else $error("range code wrong");

	a_fact_axis: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_FACT_CFG && !i_init_done_lock)
		|=> o_rdata[1:0] == $past(i_factory_axis)) else $error("axis code wrong");

	a_fact_rsvd: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(rd_ok && i_rd.addr == ADDR_FACT_CFG) |=> o_rdata[3:2] == 2'b00)
		else $error("factory reserved bits set");
endmodule : csr_regs
`default_nettype wire

/* csr_host.sv */
/*
 * host model: issues single register reads and collects the answers.
 * assumes the group answers at the taking edge, one cycle after the request is driven.
 */
`timescale 1ns/1ps
`default_nettype none
module csr_host
(
	input wire logic i_clk,
	input wire logic i_rvalid,
	input wire logic [7:0] i_rdata,
	output var csr_pkg::csr_rd_s o_rd
);
	import csr_pkg::*;
	initial o_rd = '0;
	// ok stays low when the read was refused
	task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge i_clk);
		#1 o_rd = {1'b1, a};
		@(posedge i_clk);
		// released address shows inverted, not a stale copy
		#1 o_rd = {1'b0, ~a};
		ok = i_rvalid;
		d = i_rdata;
	endtask : rd
endmodule : csr_host
`default_nettype wire

/* channel_status_and_sample_regs_tb.sv */
/*
 * testbench: reads every register through the host model and compares
 * each answer with values reckoned here. assumes the csr_pkg constants.
 */
`timescale 1ns/1ps
`default_nettype none
module channel_status_and_sample_regs_tb;
	import csr_pkg::*;
	logic clk, rst_n, prog, lim, rep, keep, stf, lock, rv, dsr, offs_o, stf_o, ok;
	csr_rd_s rd;
	csr_mode_e mode;
	csr_device_status_primary_s ds;
	logic [15:0] s0, s1;
	logic [1:0] sel0, sel1, axis, src0, src1;
	logic [3:0] scale;
	logic [7:0] rdata, d, hi;
	int mismatches, num_checks;
	csr_regs u_dut (.i_clk(clk), .i_reset_n(rst_n), .i_rd(rd), .i_mode(mode),
		.i_psi5_prog(prog), .i_offset_limit(lim), .i_tx_offs_report(rep),
		.i_psi5_keep_offs(keep), .i_selftest_fail(stf), .i_device_status_primary(ds), .i_sample0(s0),
		.i_sample1(s1), .i_sample0_source_select(sel0), .i_sample1_source_select(sel1),
		.i_init_done_lock(lock), .i_factory_scale_code(scale), .i_factory_axis(axis),
		.o_rdata(rdata), .o_rvalid(rv), .o_device_status_primary_read(dsr), .o_offset_fault(offs_o),
		.o_startup_selftest_fail_flag(stf_o), .o_sample0_source(src0),
		.o_sample1_source(src1));
	csr_host u_host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdata), .o_rd(rd));
	// ********************
	// checks and run control
	// ********************
	task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task rdc(input string n, input logic [7:0] a, input logic [7:0] e);
		u_host.rd(a, d, ok);
		chk({n, "_valid"}, {7'h0, ok}, 8'h01);
		chk(n, d, e);
	endtask : rdc
	task automatic pulse(ref logic s);
		@(posedge clk);
		#1 s = 1;
		@(posedge clk);
		#1 s = 0;
	endtask : pulse
	task test_done;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : test_done
	initial
	begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// a healthy run needs well under a thousand cycles
	initial
	begin
		#20000;
		mismatches++;
		test_done;
	end
	initial
	begin
		rst_n = 0; mode = CSR_MODE_SPI; prog = 0; lim = 0; rep = 0; keep = 0; stf = 0;
		ds = '0; s0 = '0; s1 = '0; sel0 = '0; sel1 = '0; lock = 0;
		scale = RANGE_MEDIUM; axis = AXIS_X;
		void'($urandom(32'h09a0edea));
		repeat (5) @(posedge clk);
		#1 rst_n = 1;
		rdc("s0_reset", 8'h63, 8'h00);
		rdc("s1_reset", 8'h65, 8'h00);
		for (int m = 0; m < 4; m++)
			for (int k = 0; k < 2; k++)
			begin
				mode = csr_mode_e'(m);
				prog = (m == 3);
				s0 = 16'($urandom); s1 = 16'($urandom);
				sel0 = 2'($urandom); sel1 = 2'($urandom);
				hi = k ? s1[15:8] : s0[15:8];
				rdc("low", 8'(8'h62 + 2 * k), k ? s1[7:0] : s0[7:0]);
				chk("src", {4'h0, src1, src0}, {4'h0, sel1, sel0});
				chk("no_dsr", {7'h0, dsr}, 8'h00);
				s0 = 16'($urandom); s1 = 16'($urandom);
				if (m != 2)
					hi = k ? s1[15:8] : s0[15:8];
				rdc("high", 8'(8'h63 + 2 * k), hi);
			end
		mode = CSR_MODE_SPI; prog = 0;
		ds = 7'($urandom);
		rdc("mirror", 8'h61, {ds[6], 1'b0, ds[5:0]});
		chk("dsr", {7'h0, dsr}, 8'h01);
		pulse(lim);
		rdc("offs_set", 8'h60, 8'h02);
		rdc("offs_clr", 8'h60, 8'h00);
		pulse(lim);
		pulse(rep);
		@(posedge clk);
		#1 chk("offs_rep", {7'h0, offs_o}, 8'h00);
		mode = CSR_MODE_PSI5; prog = 1; keep = 1;
		pulse(lim);
		pulse(rep);
		rdc("offs_keep", 8'h60, 8'h02);
		rdc("offs_keep2", 8'h60, 8'h02);
		keep = 0;
		rdc("offs_rel", 8'h60, 8'h02);
		prog = 0;
		u_host.rd(8'h60, d, ok);
		chk("refused", {7'h0, ok}, 8'h00);
		prog = 1;
		rdc("offs_gone", 8'h60, 8'h00);
		pulse(stf);
		rdc("stf_set", 8'h60, 8'h01);
		chk("stf_o", {7'h0, stf_o}, 8'h01);
		rdc("stf_hold", 8'h60, 8'h01);
		rst_n = 0;
		repeat (2) @(posedge clk);
		#1 rst_n = 1;
		rdc("stf_reset", 8'h60, 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			axis = 2'(i);
			scale = i[0] ? RANGE_HIGH : RANGE_MEDIUM;
			lock = 0;
			rdc("fact", 8'ha0, {scale, 2'b00, axis});
			lock = 1;
			rdc("fact_lock", 8'ha0, 8'h00);
		end
		rdc("unmapped", 8'h70, 8'h00);
		test_done;
	end
endmodule : channel_status_and_sample_regs_tb
`default_nettype wire
